//--- rtl/supply_level_detector.sv
// supply level detector control: wishbone registers, comparator sync, event and irq
// assumes analog comparator, band gap and idle indication are asynchronous levels
//
// The Wishbone interface to the registers is this design's own decision.
`include "svd_defines.svh"
module supply_level_detector
    import svd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmp_above_i,
    input wire logic bandgap_stable_i,
    input wire logic ref_stable_i,
    input wire logic device_idle_i,
    output logic detector_power_o,
    output logic [`LIMIT_MSB:0] trip_limit_select_o,
    output logic external_sense_select_o,
    output logic event_pulse_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic cmp_s;
    logic bg_s;
    logic ref_s;
    logic idle_s;

    sync3 u_sync_cmp (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(cmp_above_i),
        .sync_o(cmp_s)
    );
    sync3 u_sync_bg (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(bandgap_stable_i),
        .sync_o(bg_s)
    );
    sync3 u_sync_ref (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(ref_stable_i),
        .sync_o(ref_s)
    );
    sync3 u_sync_idle (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .async_i(device_idle_i),
        .sync_o(idle_s)
    );

    // ------------------------------------------------------------
    // control register and bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [`IRQ_BITS-1:0] stat_reg;
    logic [`IRQ_BITS-1:0] stat_next;
    logic [`IRQ_BITS-1:0] mask_reg;
    logic [`IRQ_BITS-1:0] mask_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic evt_reg;
    logic evt_next;
    logic pulse_reg;
    logic pulse_next;
    logic irq_reg;
    logic irq_next;
    logic pwr_reg;
    logic pwr_next;
    logic [`LIMIT_MSB:0] lim_reg;
    logic [`LIMIT_MSB:0] lim_next;
    logic ext_reg;
    logic ext_next;
    sense_source_t source;

    logic [31:0] wmask;
    logic [31:0] wdata;
    logic req;
    logic wr;
    logic [31:0] status_view;
    logic active;
    logic cond;
    logic evt_rise;
    logic evt_fall;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    limit_decode u_decode (
        .code_i(ctrl_reg[`LIMIT_MSB:0]),
        .source_o(source)
    );

    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_reg;
        wr = req && wb_we_i;
        // only implemented bits ever change
        wmask = lane_mask(wb_sel_i) & `VDC_WR_MASK;
        wdata = wb_dat_i;
        // hardware owned status bits are merged in on read
        status_view = ctrl_reg & `VDC_WR_MASK;
        status_view[`BIT_BG_STABLE] = bg_s;
        status_view[`BIT_REF_STABLE] = ref_s;
        status_view[`BIT_EVT_STATUS] = evt_reg;
    end

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    always_comb begin
        active = ctrl_reg[`BIT_ENABLE] && !(ctrl_reg[`BIT_HALT_IDLE] && idle_s);
        // reserved codes detect nothing, so a mistaken setting stays harmless
        active = active && (source != SRC_RESERVED);
        // comparator high means sense at or above trip point
        cond = ctrl_reg[`BIT_DIR] ? cmp_s : !cmp_s;
        evt_next = active && ref_s && cond;
        evt_rise = evt_next && !evt_reg;
        evt_fall = !evt_next && evt_reg;
        pulse_next = evt_rise;
    end

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    // the base register and its three aliases share one read view
    function automatic logic is_ctrl_adr(input logic [15:0] adr);
        is_ctrl_adr = (adr == `VDC_BASE_OFF) || (adr == `VDC_CLR_OFF) ||
            (adr == `VDC_SET_OFF) || (adr == `VDC_INV_OFF);
    endfunction

    // one place for the alias arithmetic keeps the four write flavours alike
    function automatic logic [31:0] ctrl_write(
        input logic [15:0] adr,
        input logic [31:0] cur,
        input logic [31:0] val,
        input logic [31:0] msk
    );
        ctrl_write = cur;
        case (adr)
            `VDC_BASE_OFF: begin
                ctrl_write = (cur & ~msk) | (val & msk);
            end
            `VDC_CLR_OFF: begin
                ctrl_write = cur & ~(val & msk);
            end
            `VDC_SET_OFF: begin
                ctrl_write = cur | (val & msk);
            end
            `VDC_INV_OFF: begin
                ctrl_write = cur ^ (val & msk);
            end
            default: begin
                ctrl_write = cur;
            end
        endcase
    endfunction

    // widens a status or mask word to the bus, upper bits read zero
    function automatic logic [31:0] pad_irq(input logic [`IRQ_BITS-1:0] val);
        pad_irq = 32'h0000_0000;
        pad_irq[`IRQ_BITS-1:0] = val;
    endfunction

    // ------------------------------------------------------------
    // control and mask registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (wr && is_ctrl_adr(wb_adr_i)) begin
            ctrl_next = ctrl_write(wb_adr_i, ctrl_reg, wdata, wmask);
        end
        // the mask lives in the low byte lane only
        if (wr && (wb_adr_i == `IRQ_MASK_OFF) && wb_sel_i[0]) begin
            mask_next = wdata[`IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= `VDC_RESET;
            mask_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and request
    // ------------------------------------------------------------
    always_comb begin
        stat_next = stat_reg;
        // write one to clear, low byte lane only
        if (wr && (wb_adr_i == `IRQ_STAT_OFF) && wb_sel_i[0]) begin
            stat_next = stat_reg & ~wdata[`IRQ_BITS-1:0];
        end
        // hardware set wins over a same-cycle software clear
        stat_next[0] = stat_next[0] | evt_rise;
        stat_next[1] = stat_next[1] | evt_fall;
        // built from next values so the request rises with its status bit
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_comb begin
        // every address answers, so a stray access cannot stall the bus
        ack_next = req;
        rdat_next = 32'h0000_0000;
        if (req && !wb_we_i) begin
            if (is_ctrl_adr(wb_adr_i)) begin
                rdat_next = status_view;
            end else if (wb_adr_i == `IRQ_STAT_OFF) begin
                rdat_next = pad_irq(stat_reg);
            end else if (wb_adr_i == `IRQ_MASK_OFF) begin
                rdat_next = pad_irq(mask_reg);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // ------------------------------------------------------------
    // event registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            pulse_reg <= pulse_next;
        end
    end

    // ------------------------------------------------------------
    // analog drive
    // ------------------------------------------------------------
    // the analog side follows the register one cycle late, a small cost for clean outputs
    always_comb begin
        pwr_next = ctrl_reg[`BIT_ENABLE];
        lim_next = ctrl_reg[`LIMIT_MSB:0];
        ext_next = (source == SRC_EXTERNAL);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwr_reg <= 1'b0;
            lim_reg <= '0;
            ext_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            lim_reg <= lim_next;
            ext_reg <= ext_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;
    assign detector_power_o = pwr_reg;
    assign trip_limit_select_o = lim_reg;
    assign external_sense_select_o = ext_reg;
    assign event_pulse_o = pulse_reg;
    assign irq_o = irq_reg;
endmodule

//--- pkg/svd_defines.svh
// register offsets, field positions and reset values of the supply level detector
// assumes inclusion by bare name from the rtl files; the package file does not include it
`ifndef SVD_DEFINES_SVH
`define SVD_DEFINES_SVH
`define VDC_BASE_OFF 16'h2310
`define VDC_CLR_OFF 16'h2314
`define VDC_SET_OFF 16'h2318
`define VDC_INV_OFF 16'h231C
`define IRQ_STAT_OFF 16'h2320
`define IRQ_MASK_OFF 16'h2324
`define VDC_RESET 32'h0000_0000
`define VDC_WR_MASK 32'h0000_A80F
`define BIT_ENABLE 15
`define BIT_HALT_IDLE 13
`define BIT_DIR 11
`define BIT_BG_STABLE 10
`define BIT_REF_STABLE 9
`define BIT_EVT_STATUS 8
`define LIMIT_MSB 3
`define LIMIT_EXTERNAL 4'hF
`define LIMIT_LOWEST_OK 4'h5
`define IRQ_BITS 2
`endif

//--- pkg/svd_pkg.sv
// types shared by the supply level detector files
// assumes the defines header is on the include path
package svd_pkg;
    typedef enum logic [1:0] {
        SRC_SUPPLY,
        SRC_EXTERNAL,
        SRC_RESERVED
    } sense_source_t;
endpackage

//--- rtl/sync3.sv
// three-stage synchroniser for a level from outside the clock domain
// assumes an asynchronous active-low reset; output changes once stages two and three agree
module sync3 (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic sync_o
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_i};
        out_next = out_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            out_next = stage_reg[2];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_reg <= 3'h0;
            out_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule

//--- rtl/limit_decode.sv
// decodes the trip limit code into a sense source selection
// purely combinational, no state
`include "svd_defines.svh"
module limit_decode
    import svd_pkg::*;
(
    input wire logic [`LIMIT_MSB:0] code_i,
    output svd_pkg::sense_source_t source_o
);
    always_comb begin
        if (code_i == `LIMIT_EXTERNAL) begin
            source_o = SRC_EXTERNAL;
        end else if (code_i >= `LIMIT_LOWEST_OK) begin
            source_o = SRC_SUPPLY;
        end else begin
            source_o = SRC_RESERVED;
        end
    end
endmodule

//--- dv/svd_assertions.sv
// concurrent checks on the supply level detector ports
// assumes it is bound to the design top; one clock domain
module svd_assertions (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ref_stable_i,
    input wire logic [3:0] trip_limit_select_o,
    input wire logic detector_power_o,
    input wire logic external_sense_select_o,
    input wire logic event_pulse_o
);
    // ----
    // bus and event checks
    // ----
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [15:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    a_ack_after_take: assert property (s_take |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
    a_ctl_unused_zero: assert property (s_rd(16'h2310) |-> !(wb_dat_o & ~32'h0000AF0F))
        else $error("unused control bit set");
    a_ctl_mirror: assert property (s_rd(16'h2310) |->
        wb_dat_o[15] == detector_power_o && wb_dat_o[3:0] == trip_limit_select_o)
        else $error("control outputs differ from register");
    a_ext_sel_code: assert property (external_sense_select_o == (trip_limit_select_o == 4'hF))
        else $error("external select wrong");
    a_unmapped_zero: assert property (s_rd(16'h2330) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pulse_single: assert property (event_pulse_o |=> !event_pulse_o)
        else $error("event pulse too long");
    // three cycles cover the status and pulse pipeline after power drops
    a_off_no_pulse: assert property (!detector_power_o [*3] |-> !event_pulse_o)
        else $error("event while disabled");
    a_unstable_no_pulse: assert property (!ref_stable_i [*8] |-> !event_pulse_o)
        else $error("event while reference unstable");
endmodule
bind supply_level_detector svd_assertions u_chk (.core_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ref_stable_i, .trip_limit_select_o,
    .detector_power_o, .external_sense_select_o, .event_pulse_o);

//--- dv/svd_analog_model.sv
// behavioural comparator and references behind the detector
// assumes voltages in units of 10 mV; references settle after power-up
module svd_analog_model (
    input wire logic core_clk_i,
    input wire logic power_i,
    input wire logic [3:0] code_i,
    input wire logic ext_sel_i,
    input wire logic [9:0] supply_i,
    input wire logic [9:0] ext_in_i,
    input wire logic ref_fault_i,
    output logic cmp_above_o = 1'b0,
    output logic bandgap_stable_o = 1'b0,
    output logic ref_stable_o = 1'b0
);
    localparam int trip_tab[16] = '{0, 0, 0, 0, 0, 344, 313, 292, 282, 263, 252, 240, 230, 221,
        211, 120};
    logic [3:0] warm_reg = 4'h0;
    always @(posedge core_clk_i) begin
        // an unknown enable before reset counts as off, so no unknown sticks in the loop
        warm_reg <= (power_i !== 1'b1) ? 4'h0 : warm_reg + 4'(warm_reg != 4'hF);
        bandgap_stable_o <= warm_reg > 4'h4;
        ref_stable_o <= warm_reg == 4'hF && !ref_fault_i;
        // unpowered output chatters so a missing enable gate shows up
        cmp_above_o <= (power_i === 1'b1) ? (ext_sel_i ? ext_in_i : supply_i) >= trip_tab[code_i]
            : !cmp_above_o;
    end
endmodule

//--- dv/supply_level_detector_tb_top.sv
// self-checking bench for the supply level detector
// assumes the analog model and checker are compiled before it
module supply_level_detector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, cmp_above_i, bandgap_stable_i, ref_stable_i, detector_power_o, irq_o;
    logic device_idle_i = 1'b0;
    logic ref_fault = 1'b0;
    logic [9:0] supply = 10'h0;
    logic [9:0] ext_in = 10'h0;
    logic [3:0] trip_limit_select_o, c;
    logic external_sense_select_o, event_pulse_o, en, hi, dir, m, m2, ev;
    logic [31:0] seed = 32'h0000003D;
    localparam int trip_tab[16] = '{0, 0, 0, 0, 0, 344, 313, 292, 282, 263, 252, 240, 230, 221,
        211, 120};
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int pulses, q, e, off;
    supply_level_detector uut (.core_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_above_i, .bandgap_stable_i,
        .ref_stable_i, .device_idle_i, .detector_power_o, .trip_limit_select_o,
        .external_sense_select_o, .event_pulse_o, .irq_o);
    svd_analog_model amod (.core_clk_i, .power_i(detector_power_o), .code_i(trip_limit_select_o),
        .ext_sel_i(external_sense_select_o), .supply_i(supply), .ext_in_i(ext_in),
        .ref_fault_i(ref_fault), .cmp_above_o(cmp_above_i), .bandgap_stable_o(bandgap_stable_i),
        .ref_stable_o(ref_stable_i));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic exp_evt(input logic en, hi, id, rf);
        return en && !(hi && id) && !rf;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_n(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            pulses += int'(event_pulse_o === 1'b1);
        end
    endtask
    task final_report;
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    // ----
    // sequence
    // ----
    initial begin
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        wb(0, 16'h2310, 0);
        chk(rd, 32'h0);
        wb(1, 16'h2310, 32'hFFFFFFFF);
        wb(0, 16'h2310, 0);
        chk(rd & 32'hFFFFF8FF, 32'h0000A80F);
        for (int i = 0; i < 3; i++) begin
            wb(1, 16'h2314 + 16'(4 * i), i == 2 ? 32'h2805 : 32'h8000);
            wb(0, 16'h2310, 0);
            chk(rd & 32'hFFFFF8FF, i == 0 ? 32'h280F : i == 1 ? 32'hA80F : 32'h800A);
        end
        wb(1, 16'h2330, 32'hFFFFFFFF);
        wb(0, 16'h2330, 0);
        chk(rd, 32'h0);
        for (int t = 0; t < 24; t++) begin
            seed = xs(seed);
            c = 4'(5 + seed[7:0] % 11);
            {en, hi, dir, m, m2} = {seed[13] | seed[14], seed[15], seed[9], seed[10], seed[22]};
            device_idle_i <= seed[8];
            ref_fault <= seed[11] & seed[12];
            off = 8 + int'(seed[21:16]) % 40;
            q = dir ? trip_tab[c] - off : trip_tab[c] + off;
            e = dir ? trip_tab[c] + off : trip_tab[c] - off;
            supply <= 10'(c == 4'hF ? e : q);
            ext_in <= 10'(c == 4'hF ? q : e);
            wb(1, 16'h2324, 32'h0);
            wb(1, 16'h2310, {16'h0, en, 1'b0, hi, 1'b0, dir, 7'h0, c});
            repeat (30) @(posedge core_clk_i);
            // unmask only once the reference flag can read one
            wb(1, 16'h2324, {30'h0, m2 & en & !ref_fault, m & en & !ref_fault});
            wb(1, 16'h2320, 32'h3);
            pulses = 0;
            supply <= 10'(c == 4'hF ? q : e);
            ext_in <= 10'(c == 4'hF ? e : q);
            wait_n(12);
            ev = exp_evt(en, hi, device_idle_i, ref_fault);
            wb(0, 16'h2310, 0);
            chk({29'h0, rd[10:8]}, {29'h0, en, en && !ref_fault, ev});
            chk(32'(pulses), {31'h0, ev});
            wb(0, 16'h2320, 0);
            chk(rd, {31'h0, ev});
            chk({31'h0, irq_o}, {31'h0, ev && m});
            wb(1, 16'h2320, 32'h1);
            wait_n(2);
            chk({31'h0, irq_o}, 32'h0);
            supply <= 10'(c == 4'hF ? e : q);
            ext_in <= 10'(c == 4'hF ? q : e);
            wait_n(12);
            wb(0, 16'h2310, 0);
            chk({31'h0, rd[8]}, 32'h0);
            wb(0, 16'h2320, 0);
            chk(rd, {30'h0, ev, 1'b0});
            chk({31'h0, irq_o}, {31'h0, ev && m2});
        end
        final_report();
    end
endmodule
